// ==== logic/bpp_priority.v ====
// Priority and arbitration of protection detections, one clock domain.
// Assumes comparator results arrive asynchronously from the analog front end.
`timescale 1ns/1ps
`include "bpp_defines.vh"

// Notes on behaviour
// RULE1 - Over-charge interrupts running over-discharge detection
// RULE2 - Over-discharge detection resumes if condition persists
// RULE3 - Discharge after over-charge: pull up, no stand-by
// RULE4 - Over-charge continues when over-current came first
// RULE5 - Over-charge first: interrupt over-current, release node
// RULE6 - Over-current first: pull node down via low resistor
// RULE7 - Over-discharge continues when over-current came first
// RULE8 - Over-discharge first interrupts over-current detection
// RULE9 - Discharge after current: drop pull-down, pull up, stand-by
// RULE10 - Over-discharge first: pull up and enter stand-by
// RULE11 - Short-circuit evaluated independently of other detections
// RULE12 - Excessive-charger inhibited during discharge-side detections
// RULE13 - Excessive-charger delay starts after discharge output high
// RULE14 - Drive charge and discharge block outputs low
// RULE15 - Shorten select cuts counter delays, not short-circuit
// RULE16 - Synchronise every comparator result before use
module bpp_priority #(
    parameter [31:0] OC_DLY  = `BPP_MS_CYC(`BPP_T_OC_MS),
    parameter [31:0] OCR_DLY = `BPP_MS_CYC(`BPP_T_OCR_MS),
    parameter [31:0] OD_DLY  = `BPP_MS_CYC(`BPP_T_OD_MS),
    parameter [31:0] ODR_DLY = `BPP_MS_CYC(`BPP_T_ODR_MS),
    parameter [31:0] OI_DLY  = `BPP_MS_CYC(`BPP_T_OI_MS),
    parameter [31:0] OIR_DLY = `BPP_MS_CYC(`BPP_T_OIR_MS),
    parameter [31:0] XC_DLY  = `BPP_MS_CYC(`BPP_T_XC_MS),
    parameter [31:0] SC_DLY  = `BPP_US_CYC(`BPP_T_SC_US)
) (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire       clk_en,
    input  wire       ovchg_cmp,
    input  wire       ovdis_cmp,
    input  wire       ovcur_cmp,
    input  wire       short_cmp,
    input  wire       xchg_cmp,
    input  wire       shorten_sel,
    output reg        chg_on_q,
    output reg        dis_on_q,
    output reg  [1:0] vminus_pull_q,
    output reg        standby_q
);

// ------------------------------------------------------------------
// Input synchronisers
// ------------------------------------------------------------------
reg  [5:0] sync1_q;        // First stage, read only by second stage
reg  [5:0] sync2_q;        // Second stage, safe to use
wire       oc_s  = sync2_q[0];
wire       od_s  = sync2_q[1];
wire       oi_s  = sync2_q[2];
wire       sc_s  = sync2_q[3];
wire       xc_s  = sync2_q[4];
wire       sh_s  = sync2_q[5];

// Both stages clocked together; analog levels are slow anyway
always @(posedge clk_sys) begin
    if (rst) begin
        sync1_q <= 6'h00;
        sync2_q <= 6'h00;
    end else if (clk_en) begin
        sync1_q <= {shorten_sel, xchg_cmp, short_cmp, ovcur_cmp, ovdis_cmp, ovchg_cmp};
        sync2_q <= sync1_q; // see RULE16
    end
end

// ------------------------------------------------------------------
// Delay selection
// ------------------------------------------------------------------
// Counter delays shrink in shorten mode; short-circuit never does
function [31:0] eff;
    input [31:0] d;
    input        s;
    begin
        eff = s ? ((d >> `BPP_SHORT_SHIFT) | 32'h1) : d; // see RULE15
    end
endfunction

// ------------------------------------------------------------------
// Detection state
// ------------------------------------------------------------------
reg        oc_det_q;       // Over-charge detected
reg        od_det_q;       // Over-discharge detected
reg        oi_det_q;       // Over-current detected
reg        sc_det_q;       // Short circuit detected
reg        xc_det_q;       // Excessive charger detected
reg        od_after_oc_q;  // Discharge detected while over-charge held
reg [31:0] oc_cnt_q;       // Over-charge timing
reg [31:0] od_cnt_q;       // Over-discharge timing
reg [31:0] oi_cnt_q;       // Over-current timing
reg [31:0] sc_cnt_q;       // Short-circuit timing
reg [31:0] xc_cnt_q;       // Excessive-charger timing

// Over-charge has priority over discharge-side timing
wire oc_busy  = oc_s | oc_det_q;
// Over-discharge timing paused while over-charge pending, then resumes
wire od_run   = od_s & ~(oc_s & ~oc_det_q);                  // see RULE1 see RULE2
// Over-current blocked when over-charge or over-discharge came first
wire oi_block = oc_det_q | od_det_q;                          // see RULE5 see RULE8
// Excessive-charger inhibited by any discharge-side detection
wire xc_block = od_det_q | oi_det_q | sc_det_q | ~dis_on_q;   // see RULE12 see RULE13

// Each detection timing and state, release also after delay except short circuit
always @(posedge clk_sys) begin
    if (rst) begin
        oc_det_q      <= 1'b0;
        od_det_q      <= 1'b0;
        oi_det_q      <= 1'b0;
        sc_det_q      <= 1'b0;
        xc_det_q      <= 1'b0;
        od_after_oc_q <= 1'b0;
        oc_cnt_q      <= 32'h0;
        od_cnt_q      <= 32'h0;
        oi_cnt_q      <= 32'h0;
        sc_cnt_q      <= 32'h0;
        xc_cnt_q      <= 32'h0;
    end else if (clk_en) begin
        // Over-charge runs regardless of over-current
        if (oc_s != oc_det_q) begin                           // see RULE4
            if (oc_cnt_q + 32'h1 >= eff(oc_det_q ? OCR_DLY : OC_DLY, sh_s)) begin
                oc_det_q <= oc_s;
                oc_cnt_q <= 32'h0;
            end else begin
                oc_cnt_q <= oc_cnt_q + 32'h1;
            end
        end else begin
            oc_cnt_q <= 32'h0;
        end
        // Over-discharge runs alongside over-current
        if (od_det_q ? ~od_s : od_run) begin                  // see RULE7
            if (od_cnt_q + 32'h1 >= eff(od_det_q ? ODR_DLY : OD_DLY, sh_s)) begin
                od_det_q      <= ~od_det_q;
                od_after_oc_q <= ~od_det_q & oc_busy;
                od_cnt_q      <= 32'h0;
            end else begin
                od_cnt_q <= od_cnt_q + 32'h1;
            end
        end else if (od_det_q | ~od_s) begin
            // Cleared on a broken release or a lost condition; held while paused
            od_cnt_q <= 32'h0;
        end
        // Over-current, interrupted by earlier charge/discharge state
        if (oi_block & ~oi_det_q) begin
            oi_cnt_q <= 32'h0;
        end else if (oi_s != oi_det_q) begin
            if (oi_cnt_q + 32'h1 >= eff(oi_det_q ? OIR_DLY : OI_DLY, sh_s)) begin
                oi_det_q <= oi_s;
                oi_cnt_q <= 32'h0;
            end else begin
                oi_cnt_q <= oi_cnt_q + 32'h1;
            end
        end else begin
            oi_cnt_q <= 32'h0;
        end
        // Discharge detection drops a running over-current detection
        if (od_det_q & oi_det_q) begin
            oi_det_q <= 1'b0;                                 // see RULE9
        end
        // Short circuit: fixed delay, no interaction
        if (sc_s & ~sc_det_q) begin                           // see RULE11
            if (sc_cnt_q + 32'h1 >= SC_DLY) begin
                sc_det_q <= 1'b1;
                sc_cnt_q <= 32'h0;
            end else begin
                sc_cnt_q <= sc_cnt_q + 32'h1;
            end
        end else begin
            sc_cnt_q <= 32'h0;
            // Released with over-current release condition
            if (sc_det_q & ~oi_s & ~sc_s) begin
                sc_det_q <= 1'b0;
            end
        end
        // Excessive charger timing, only once discharge output high
        if (xc_block & ~xc_det_q) begin
            xc_cnt_q <= 32'h0;
        end else if (xc_s != xc_det_q) begin
            if (xc_cnt_q + 32'h1 >= eff(XC_DLY, sh_s)) begin
                xc_det_q <= xc_s;
                xc_cnt_q <= 32'h0;
            end else begin
                xc_cnt_q <= xc_cnt_q + 32'h1;
            end
        end else begin
            xc_cnt_q <= 32'h0;
        end
    end
end

// ------------------------------------------------------------------
// Output drive
// ------------------------------------------------------------------
// All outputs registered so switches never see combinational glitches
always @(posedge clk_sys) begin
    if (rst) begin
        chg_on_q      <= 1'b1;
        dis_on_q      <= 1'b1;
        vminus_pull_q <= `BPP_PULL_NONE;
        standby_q     <= 1'b0;
    end else if (clk_en) begin
        chg_on_q <= ~(oc_det_q | xc_det_q);                   // see RULE14
        dis_on_q <= ~(od_det_q | oi_det_q | sc_det_q);        // see RULE14
        if (od_det_q) begin
            vminus_pull_q <= `BPP_PULL_UP;                    // see RULE3 see RULE10
            standby_q     <= ~od_after_oc_q;                  // see RULE3 see RULE9
        end else if (sc_det_q | oi_det_q) begin
            // Over-current detected first keeps its pull-down through a later
            // over-charge; over-charge first never lets over-current detect
            vminus_pull_q <= `BPP_PULL_DN;                    // see RULE6
            standby_q     <= 1'b0;
        end else begin
            vminus_pull_q <= `BPP_PULL_NONE;                  // see RULE5
            standby_q     <= 1'b0;
        end
    end
end

endmodule

// ==== logic/bpp_defines.vh ====
// Constants for the battery protection priority block.
// Assumes a 20 MHz system clock; delay counts derive from times below.
`ifndef BPP_DEFINES_VH
`define BPP_DEFINES_VH

// ------------------------------------------------------------------
// Clock and delay times
// ------------------------------------------------------------------
`define BPP_CLK_HZ        20000000
`define BPP_T_OC_MS       1000
`define BPP_T_OCR_MS      40
`define BPP_T_OD_MS       100
`define BPP_T_ODR_MS      1
`define BPP_T_OI_MS       10
`define BPP_T_OIR_MS      1
`define BPP_T_XC_MS       10
`define BPP_T_SC_US       300
`define BPP_MS_CYC(ms)    (((ms) * (`BPP_CLK_HZ / 1000)))
`define BPP_US_CYC(us)    (((us) * (`BPP_CLK_HZ / 1000000)))
`define BPP_SHORT_SHIFT   6
`define BPP_CNT_W         32

// ------------------------------------------------------------------
// Pull path codes of the charger-minus node
// ------------------------------------------------------------------
`define BPP_PULL_NONE     2'h0
`define BPP_PULL_DN       2'h1
`define BPP_PULL_UP       2'h2

`endif

// ==== verif/bpp_pack_model.sv ====
// Cells, charger and load, seen as the comparator levels that they cause.
// Assumes the bench calls set_cond just after a falling clock edge.
`timescale 1ns/1ps
module bpp_pack_model (
    output wire ovchg_cmp,
    output wire ovdis_cmp,
    output wire ovcur_cmp,
    output wire short_cmp,
    output wire xchg_cmp,
    output wire shorten_sel
);
    reg [5:0] lvl_q = 6'h00; // Levels are held until the bench changes them
    // Bit 3 is over-current and bit 2 short circuit, as the bench codes them
    assign {shorten_sel, xchg_cmp, ovcur_cmp, short_cmp, ovdis_cmp, ovchg_cmp} = lvl_q;
    // New pack condition; a level is never glitched in between
    task set_cond(input [5:0] v);
        lvl_q = v;
    endtask
endmodule

// ==== verif/bpp_priority_properties.sv ====
// Checker for the detection priority block, watching its top ports only.
// Assumes clk_en stays high, so every edge counts.
`timescale 1ns/1ps
`include "bpp_defines.vh"
module bpp_priority_chk (
    input wire       clk_sys,
    input wire       rst,
    input wire       ovchg_cmp,
    input wire       ovdis_cmp,
    input wire       ovcur_cmp,
    input wire       short_cmp,
    input wire [1:0] vminus_pull_q,
    input wire       chg_on_q,
    input wire       dis_on_q,
    input wire       standby_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Two sync stages, the detection register and the output register
    sequence s_dis_cause;
        $past(ovdis_cmp || ovcur_cmp || short_cmp, 4);
    endsequence
    sequence s_chg_cause;
        $past(ovchg_cmp, 4);
    endsequence
    property p_rst; $fell(rst) |-> chg_on_q && dis_on_q && !standby_q && vminus_pull_q == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_dis_fall; $fell(dis_on_q) |-> s_dis_cause; endproperty
    a_dis_fall: assert property (p_dis_fall) else $error("discharge blocked with no cause");
    property p_xc_gate; $fell(chg_on_q) && !dis_on_q |-> s_chg_cause; endproperty
    a_xc_gate: assert property (p_xc_gate) else $error("charger fault while discharge off");
    property p_stby_pull; standby_q |-> vminus_pull_q == `BPP_PULL_UP; endproperty
    a_stby_pull: assert property (p_stby_pull) else $error("stand-by without pull up");
    property p_stby_dis; standby_q |-> !dis_on_q; endproperty
    a_stby_dis: assert property (p_stby_dis) else $error("stand-by with discharge on");
    property p_dn_dis; vminus_pull_q == `BPP_PULL_DN |-> !dis_on_q; endproperty
    a_dn_dis: assert property (p_dn_dis) else $error("pull down without detection");
    property p_stby_chg; $rose(standby_q) |-> chg_on_q; endproperty
    a_stby_chg: assert property (p_stby_chg) else $error("stand-by during charge block");
    property p_pull_code; vminus_pull_q != 2'h3; endproperty
    a_pull_code: assert property (p_pull_code) else $error("illegal pull code");
endmodule
bind bpp_priority bpp_priority_chk i_chk (.clk_sys(clk_sys), .rst(rst), .ovchg_cmp(ovchg_cmp),
    .ovdis_cmp(ovdis_cmp), .ovcur_cmp(ovcur_cmp), .short_cmp(short_cmp),
    .vminus_pull_q(vminus_pull_q), .chg_on_q(chg_on_q), .dis_on_q(dis_on_q),
    .standby_q(standby_q));

// ==== verif/bpp_priority_tb_top.sv ====
// Bench for the detection priority block with every delay set to 20 cycles.
// Assumes the pack model drives comparators; clk_en is held high throughout.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module bpp_priority_tb_top;
    localparam [31:0] D = 32'h14; // Short delays keep the run brief
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    wire a, b, c, s, x, t, chg, dis, stb;
    wire [1:0] pul;
    wire [4:0] st = {chg, dis, pul, stb}; // Packed view: charge, discharge, pull, stand-by
    int err_total = 0;
    int n_tests = 0;
    bpp_pack_model i_pack (.ovchg_cmp(a), .ovdis_cmp(b), .ovcur_cmp(c), .short_cmp(s),
        .xchg_cmp(x), .shorten_sel(t));
    bpp_priority #(.OC_DLY(D), .OCR_DLY(D), .OD_DLY(D), .ODR_DLY(D), .OI_DLY(D), .OIR_DLY(D),
        .XC_DLY(D), .SC_DLY(D)) i_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
        .ovchg_cmp(a), .ovdis_cmp(b), .ovcur_cmp(c), .short_cmp(s), .xchg_cmp(x),
        .shorten_sel(t), .chg_on_q(chg), .dis_on_q(dis), .vminus_pull_q(pul), .standby_q(stb));
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    // Set a condition, then let n falling edges pass
    task go(input [5:0] v, input int n);
        i_pack.set_cond(v);
        repeat (n) @(negedge clk_sys);
    endtask
    // Fresh start between scenarios so no release timing is assumed
    task rs;
        rst = 1'b1;
        go(6'h00, 2);
        rst = 1'b0;
    endtask
    task t_cur_dis;
        rs; go(6'h08, 26); `CHK(st, 5'h12)
        go(6'h0A, 30); `CHK(st, 5'h15)
    endtask
    task t_dis_cur;
        rs; go(6'h02, 5); go(6'h0A, 25); `CHK(st, 5'h15)
    endtask
    task t_chg_cur;
        rs; go(6'h01, 5); go(6'h09, 25); `CHK(st, 5'h08)
        rs; go(6'h08, 2); go(6'h09, 28); `CHK(st, 5'h02)
    endtask
    task t_chg_dis;
        rs; go(6'h02, 10); go(6'h03, 18); `CHK(dis, 1'b1)
        go(6'h03, 30); `CHK(st, 5'h04)
    endtask
    task t_short_xc;
        rs; go(6'h01, 30); go(6'h05, 30); `CHK(st[4:3], 2'h0)
        rs; go(6'h02, 26); go(6'h12, 30); `CHK(chg, 1'b1)
        go(6'h10, 40); `CHK(chg, 1'b1)
        go(6'h10, 8); `CHK(chg, 1'b0)
    endtask
    task t_shorten;
        rs; go(6'h28, 3); `CHK(dis, 1'b1)
        go(6'h28, 5); `CHK(dis, 1'b0)
        rs; go(6'h24, 8); `CHK(dis, 1'b1)
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys); `CHK(st, 5'h18)
        t_cur_dis; t_dis_cur; t_chg_cur; t_chg_dis; t_short_xc; t_shorten;
        conclude;
    end
endmodule
